// ### core/bmam_cfg.svh
// Constants for the boot mode and address map block
`ifndef BMAM_CFG_SVH
`define BMAM_CFG_SVH
// Register byte offsets on APB
`define BMAM_OFF_CALL_TABLE_BASE_POINTER_REG 12'h000
`define BMAM_OFF_DH_PMC 12'h004
`define BMAM_OFF_DL_PMC 12'h008
`define BMAM_OFF_CT_PMC 12'h00c
`define BMAM_OFF_CM_PMC 12'h010
`define BMAM_OFF_BUSW 12'h014
`define BMAM_OFF_STATUS 12'h018
`define BMAM_OFF_PC_CALC 12'h01c
`define BMAM_OFF_PC_RES 12'h020
`define BMAM_OFF_DA_CALC 12'h024
`define BMAM_OFF_DA_RES 12'h028
`define BMAM_OFF_VEC_SEL 12'h02c
`define BMAM_OFF_VEC_RES 12'h030
// Edges counted after reset before the mode is latched
`define BMAM_SETTLE_CNT 2'h2
// Call table base pointer writable bits
`define BMAM_CALL_TABLE_BASE_POINTER_MASK 32'h03ff_fffe
// Port mode-control reset values
`define BMAM_DH_EXT 8'hff
`define BMAM_DL_EXT 16'hffff
`define BMAM_CT_EXT 8'h53
`define BMAM_CM_EXT 8'h03
`define BMAM_DH_INT 8'h00
`define BMAM_DL_INT 16'h0000
`define BMAM_CT_INT 8'h00
`define BMAM_CM_INT 8'h00
`define BMAM_BUSW_RST 16'h5555
// Address map
`define BMAM_PC_MASK 32'h03ff_ffff
`define BMAM_PHYS_MASK 32'h0fff_ffff
`define BMAM_PIO_WIN_LO 32'h03ff_f000
`define BMAM_ROM_TOP 32'h000f_ffff
`define BMAM_ROM_POP_TOP 32'h0001_ffff
// Vector table
`define BMAM_VEC_RESET 32'h0000_0000
`define BMAM_VEC_NMI 32'h0000_0010
`define BMAM_VEC_TRAPA 32'h0000_0040
`define BMAM_VEC_TRAPB 32'h0000_0050
`define BMAM_VEC_ILGOP 32'h0000_0060
`define BMAM_VEC_EXTP0 32'h0000_0080
`define BMAM_VEC_DMA0 32'h0000_0290
`define BMAM_VEC_AD0 32'h0000_03a0
`define BMAM_VEC_AD1 32'h0000_03b0
`define BMAM_VEC_CM5 32'h0000_0450
`define BMAM_VEC_STEP 32'h0000_0010
`define BMAM_NUM_EXTP 3'h5
`define BMAM_NUM_DMA 3'h4
`endif

// ### core/bmam_pkg.sv
// Types for the boot mode and address map block
package bmam_pkg;
    typedef enum logic [1:0] {
        BMAM_MODE_EXT,
        BMAM_MODE_INT,
        BMAM_MODE_FLASH,
        BMAM_MODE_BAD
    } bmam_mode_e;

    typedef struct packed {
        logic [7:0] dh;
        logic [15:0] dl;
        logic [7:0] ct;
        logic [7:0] cm;
    } bmam_pmc_s;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } bmam_apb_req_s;
endpackage

// ### core/bmam_top.sv
// Boot mode decode, address wrap and vector table block with APB registers
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "bmam_cfg.svh"

module bmam_top (
    input wire logic pclk, // APB clock, 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire bmam_pkg::bmam_apb_req_s apb_req, // APB request group
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic mode_select_primary_pin, // Primary mode pin (logic level)
    input wire logic mode_select_secondary_pin, // Secondary mode pin
    input wire logic mode_or_program_voltage_pin, // High when program voltage present
    input wire logic flash_variant, // Strap: device is the flash variant
    output logic [1:0] boot_mode, // Decoded mode, bmam_mode_e code
    output bmam_pkg::bmam_pmc_s pmc_out, // Port pin control mode bits
    output logic bus_16bit, // External data bus forced 16 bits
    output logic rom_access_en, // Internal ROM fetch and data allowed
    output logic flash_prog_en, // External programmer may write flash
    output logic [31:0] reset_entry // Reset branch target
);
    // Pin synchronisers, two stages each
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else if (clk_en) begin
            pin_s1_r <= {flash_variant, mode_or_program_voltage_pin,
                         mode_select_primary_pin, mode_select_secondary_pin};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Mode decode from synchronised pins
    bmam_pkg::bmam_mode_e mode_nxt;
    always_comb begin
        if (pin_s2_r[3] && pin_s2_r[2] && pin_s2_r[0]) begin
            mode_nxt = bmam_pkg::BMAM_MODE_FLASH;
        end else if (!pin_s2_r[1] && !pin_s2_r[2] && !pin_s2_r[0]) begin
            mode_nxt = bmam_pkg::BMAM_MODE_EXT;
        end else if (!pin_s2_r[1] && !pin_s2_r[2] && pin_s2_r[0]) begin
            mode_nxt = bmam_pkg::BMAM_MODE_INT;
        end else begin
            mode_nxt = bmam_pkg::BMAM_MODE_BAD;
        end
    end

    // Mode latched once after reset release; pins are held fixed afterwards
    bmam_pkg::bmam_mode_e mode_r;
    logic [1:0] settle_r;
    logic init_done_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= bmam_pkg::BMAM_MODE_BAD;
            settle_r <= 2'h0;
            init_done_r <= 1'b0;
        end else if (clk_en && !init_done_r) begin
            if (settle_r == `BMAM_SETTLE_CNT) begin
                mode_r <= mode_nxt;
                init_done_r <= 1'b1;
            end else begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    // APB decode
    logic acc_w;
    logic wr_w;
    logic [11:0] a_w;
    logic hit_w;
    assign a_w = apb_req.paddr;
    assign acc_w = clk_en && apb_req.psel && apb_req.penable && !pready;
    assign wr_w = acc_w && apb_req.pwrite && hit_w && init_done_r;
    always_comb begin
        if (a_w == `BMAM_OFF_CALL_TABLE_BASE_POINTER_REG || a_w == `BMAM_OFF_DH_PMC ||
            a_w == `BMAM_OFF_DL_PMC || a_w == `BMAM_OFF_CT_PMC ||
            a_w == `BMAM_OFF_CM_PMC || a_w == `BMAM_OFF_BUSW ||
            a_w == `BMAM_OFF_STATUS || a_w == `BMAM_OFF_PC_CALC ||
            a_w == `BMAM_OFF_PC_RES || a_w == `BMAM_OFF_DA_CALC ||
            a_w == `BMAM_OFF_DA_RES || a_w == `BMAM_OFF_VEC_SEL ||
            a_w == `BMAM_OFF_VEC_RES) begin
            hit_w = 1'b1;
        end else begin
            hit_w = 1'b0;
        end
    end

    // Call table base pointer
    logic [31:0] call_table_base_pointer_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_table_base_pointer_r <= 32'h0;
        end else if (wr_w && a_w == `BMAM_OFF_CALL_TABLE_BASE_POINTER_REG) begin
            call_table_base_pointer_r <= apb_req.pwdata & `BMAM_CALL_TABLE_BASE_POINTER_MASK;
        end
    end

    // Port mode-control registers and bus width; load mode reset values
    bmam_pkg::bmam_pmc_s pmc_r;
    logic [15:0] busw_r;
    logic loaded_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pmc_r <= '0;
            busw_r <= `BMAM_BUSW_RST;
            loaded_r <= 1'b0;
        end else if (clk_en) begin
            if (init_done_r && !loaded_r) begin
                loaded_r <= 1'b1;
                if (mode_r == bmam_pkg::BMAM_MODE_EXT) begin
                    pmc_r.dh <= `BMAM_DH_EXT;
                    pmc_r.dl <= `BMAM_DL_EXT;
                    pmc_r.ct <= `BMAM_CT_EXT;
                    pmc_r.cm <= `BMAM_CM_EXT;
                end else begin
                    pmc_r.dh <= `BMAM_DH_INT;
                    pmc_r.dl <= `BMAM_DL_INT;
                    pmc_r.ct <= `BMAM_CT_INT;
                    pmc_r.cm <= `BMAM_CM_INT;
                end
            end else if (wr_w && loaded_r) begin
                // Software switches pins to control mode
                if (a_w == `BMAM_OFF_DH_PMC) begin
                    pmc_r.dh <= apb_req.pwdata[7:0];
                end else if (a_w == `BMAM_OFF_DL_PMC) begin
                    pmc_r.dl <= apb_req.pwdata[15:0];
                end else if (a_w == `BMAM_OFF_CT_PMC) begin
                    pmc_r.ct <= apb_req.pwdata[7:0];
                end else if (a_w == `BMAM_OFF_CM_PMC) begin
                    pmc_r.cm <= apb_req.pwdata[7:0];
                end else if (a_w == `BMAM_OFF_BUSW) begin
                    busw_r <= apb_req.pwdata[15:0];
                end
            end
        end
    end

    // Branch target calculator: 26-bit wrap inside program space
    logic [31:0] pc_calc_r;
    logic [31:0] pc_res_w;
    logic pc_bad_w;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_calc_r <= 32'h0;
        end else if (wr_w && a_w == `BMAM_OFF_PC_CALC) begin
            pc_calc_r <= apb_req.pwdata;
        end
    end
    // Sum of base and offset, upper six bits dropped
    assign pc_res_w = (call_table_base_pointer_r + pc_calc_r) & `BMAM_PC_MASK;
    assign pc_bad_w = (pc_res_w >= `BMAM_PIO_WIN_LO);

    // Operand address calculator: 32-bit wrap, then 28-bit physical
    logic [31:0] da_calc_r;
    logic [31:0] da_sum_w;
    logic [31:0] da_phys_w;
    logic da_rom_w;
    logic da_undef_w;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            da_calc_r <= 32'h0;
        end else if (wr_w && a_w == `BMAM_OFF_DA_CALC) begin
            da_calc_r <= apb_req.pwdata;
        end
    end
    assign da_sum_w = call_table_base_pointer_r + da_calc_r;
    assign da_phys_w = da_sum_w & `BMAM_PHYS_MASK;
    assign da_rom_w = (da_phys_w <= `BMAM_ROM_TOP);
    assign da_undef_w = da_rom_w && (da_phys_w > `BMAM_ROM_POP_TOP);

    // Vector lookup: source code selects handler address
    logic [7:0] vec_sel_r;
    logic [31:0] vec_addr_w;
    logic vec_ok_w;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_sel_r <= 8'h0;
        end else if (wr_w && a_w == `BMAM_OFF_VEC_SEL) begin
            vec_sel_r <= apb_req.pwdata[7:0];
        end
    end
    // Codes: 0 reset,1 nmi,2 trapA,3 trapB,4 ilgop,8+n ext pin,16+n dma,24/25 ad,26 cm
    always_comb begin
        vec_ok_w = 1'b1;
        if (vec_sel_r == 8'h00) begin
            vec_addr_w = `BMAM_VEC_RESET;
        end else if (vec_sel_r == 8'h01) begin
            vec_addr_w = `BMAM_VEC_NMI;
        end else if (vec_sel_r == 8'h02) begin
            vec_addr_w = `BMAM_VEC_TRAPA;
        end else if (vec_sel_r == 8'h03) begin
            vec_addr_w = `BMAM_VEC_TRAPB;
        end else if (vec_sel_r == 8'h04) begin
            vec_addr_w = `BMAM_VEC_ILGOP;
        end else if (vec_sel_r[7:3] == 5'h01 && vec_sel_r[2:0] < `BMAM_NUM_EXTP) begin
            vec_addr_w = `BMAM_VEC_EXTP0 + {25'h0, vec_sel_r[2:0], 4'h0};
        end else if (vec_sel_r[7:3] == 5'h02 && vec_sel_r[2:0] < `BMAM_NUM_DMA) begin
            vec_addr_w = `BMAM_VEC_DMA0 + {25'h0, vec_sel_r[2:0], 4'h0};
        end else if (vec_sel_r == 8'h18) begin
            vec_addr_w = `BMAM_VEC_AD0;
        end else if (vec_sel_r == 8'h19) begin
            vec_addr_w = `BMAM_VEC_AD1;
        end else if (vec_sel_r == 8'h1a) begin
            vec_addr_w = `BMAM_VEC_CM5;
        end else begin
            vec_addr_w = `BMAM_VEC_RESET;
            vec_ok_w = 1'b0;
        end
    end

    // Read mux and APB answer, one wait state in each access phase
    logic [31:0] rd_nxt;
    always_comb begin
        if (a_w == `BMAM_OFF_CALL_TABLE_BASE_POINTER_REG) begin
            rd_nxt = call_table_base_pointer_r;
        end else if (a_w == `BMAM_OFF_DH_PMC) begin
            rd_nxt = {24'h0, pmc_r.dh};
        end else if (a_w == `BMAM_OFF_DL_PMC) begin
            rd_nxt = {16'h0, pmc_r.dl};
        end else if (a_w == `BMAM_OFF_CT_PMC) begin
            rd_nxt = {24'h0, pmc_r.ct};
        end else if (a_w == `BMAM_OFF_CM_PMC) begin
            rd_nxt = {24'h0, pmc_r.cm};
        end else if (a_w == `BMAM_OFF_BUSW) begin
            rd_nxt = {16'h0, busw_r};
        end else if (a_w == `BMAM_OFF_STATUS) begin
            rd_nxt = {27'h0, loaded_r, init_done_r, 1'b0, mode_r};
        end else if (a_w == `BMAM_OFF_PC_CALC) begin
            rd_nxt = pc_calc_r;
        end else if (a_w == `BMAM_OFF_PC_RES) begin
            rd_nxt = {pc_bad_w, pc_res_w[30:0]};
        end else if (a_w == `BMAM_OFF_DA_CALC) begin
            rd_nxt = da_calc_r;
        end else if (a_w == `BMAM_OFF_DA_RES) begin
            rd_nxt = {da_rom_w, da_undef_w, 2'h0, da_phys_w[27:0]};
        end else if (a_w == `BMAM_OFF_VEC_SEL) begin
            rd_nxt = {24'h0, vec_sel_r};
        end else if (a_w == `BMAM_OFF_VEC_RES) begin
            rd_nxt = {vec_ok_w, vec_addr_w[30:0]};
        end else begin
            rd_nxt = 32'h0;
        end
    end

    // APB response registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= acc_w;
            pslverr <= acc_w && !hit_w;
            if (acc_w && !apb_req.pwrite) begin
                prdata <= rd_nxt;
            end
        end
    end

    // Mode-driven outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_mode <= bmam_pkg::BMAM_MODE_BAD;
            pmc_out <= '0;
            bus_16bit <= 1'b0;
            rom_access_en <= 1'b0;
            flash_prog_en <= 1'b0;
            reset_entry <= 32'h0;
        end else if (clk_en) begin
            boot_mode <= mode_r;
            pmc_out <= pmc_r;
            bus_16bit <= loaded_r && mode_r == bmam_pkg::BMAM_MODE_EXT;
            rom_access_en <= loaded_r && mode_r != bmam_pkg::BMAM_MODE_EXT;
            flash_prog_en <= loaded_r && mode_r == bmam_pkg::BMAM_MODE_FLASH;
            reset_entry <= `BMAM_VEC_RESET;
        end
    end
endmodule
`default_nettype wire

// ### verif/bmam_chk_sva.sv
// Port assertions for the boot mode and address map block
`timescale 1ns/100ps
`default_nettype none
module bmam_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic clk_en, // Clock enable
    input wire bmam_pkg::bmam_apb_req_s apb_req, // APB request
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic mode_select_primary_pin, // Primary pin
    input wire logic mode_select_secondary_pin, // Secondary pin
    input wire logic mode_or_program_voltage_pin, // Voltage pin
    input wire logic flash_variant, // Flash strap
    input wire logic [1:0] boot_mode, // Decoded mode
    input wire logic bus_16bit, // Narrow bus
    input wire logic rom_access_en, // ROM enable
    input wire logic flash_prog_en, // Programmer enable
    input wire logic [31:0] reset_entry // Reset target
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Read answer qualifier
    logic rd_ok;
    assign rd_ok = pready && !apb_req.pwrite;
    a_ready_pulse: assert property (apb_req.psel && apb_req.penable && !pready && clk_en
        |=> pready ##1 !pready) else $error("ready late or long");
    a_call_table_base_pointer_zero: assert property (rd_ok && apb_req.paddr == 12'h000
        |-> prdata[31:26] == 6'h00 && !prdata[0]) else $error("base pointer bits set");
    a_pc_top: assert property (rd_ok && apb_req.paddr == 12'h020
        |-> prdata[30:26] == 5'h00) else $error("program counter top bits set");
    a_vec_grid: assert property (rd_ok && apb_req.paddr == 12'h030
        |-> (prdata[31] && prdata[3:0] == 4'h0) || prdata == 32'h0) else $error("bad vector");
    a_ext_decode: assert property (boot_mode == 2'h0
        |-> !mode_select_primary_pin && !mode_select_secondary_pin) else $error("ext decode");
    a_int_decode: assert property (boot_mode == 2'h1
        |-> !mode_select_primary_pin && mode_select_secondary_pin) else $error("int decode");
    a_flash_decode: assert property (flash_prog_en |-> boot_mode == 2'h2
        && flash_variant && mode_or_program_voltage_pin && mode_select_secondary_pin)
        else $error("flash decode");
    a_rom_blocked: assert property (boot_mode == 2'h0 |-> !rom_access_en)
        else $error("ROM open in external boot");
    a_narrow_bus: assert property (bus_16bit |-> boot_mode == 2'h0)
        else $error("narrow bus outside external boot");
    a_ext_loads: assert property ($changed(boot_mode) && boot_mode == 2'h0
        |-> ##[1:3] bus_16bit) else $error("external boot not loaded");
    a_mode_held: assert property (boot_mode != 2'h3 |=> $stable(boot_mode))
        else $error("mode changed");
    a_entry_zero: assert property (reset_entry == 32'h0)
        else $error("reset entry not zero");
endmodule
`default_nettype wire

// ### verif/bmam_pin_model.sv
// Board straps that hold the mode pins
`timescale 1ns/100ps
`default_nettype none
module bmam_pin_model (
    input wire logic [1:0] sel, // Requested mode code
    output logic prim, // Primary mode pin
    output logic sec, // Secondary mode pin
    output logic vpp, // Program voltage present
    output logic fv // Flash variant strap
);
    // Fixed levels per mode; the bench alters sel only inside reset
    always_comb begin
        prim = sel[1];
        sec = sel[0] ^ sel[1];
        vpp = sel == 2'h2;
        fv = sel[1];
    end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the boot mode and address map block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] sel = 2'h0;
    bmam_pkg::bmam_apb_req_s req = '0;
    logic [31:0] prdata, reset_entry, q;
    logic pready, pslverr, prim, sec, vpp, fv, bus_16bit, rom_en, fl_en, e;
    logic [1:0] boot_mode;
    bmam_pkg::bmam_pmc_s pmc_out;
    int mismatches = 0;
    int check_count = 0;
    logic [31:0] pe [4] = '{32'hff, 32'hffff, 32'h53, 32'h03};
    logic [31:0] vc [14] = '{0, 1, 2, 3, 4, 8, 12, 16, 19, 24, 25, 26, 5, 13};
    logic [31:0] va [14] = '{32'h0, 32'h10, 32'h40, 32'h50, 32'h60, 32'h80, 32'hc0,
        32'h290, 32'h2c0, 32'h3a0, 32'h3b0, 32'h450, 32'h0, 32'h0};
    bmam_pin_model u_pins (.sel(sel), .prim(prim), .sec(sec), .vpp(vpp), .fv(fv));
    bmam_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_select_primary_pin(prim),
        .mode_select_secondary_pin(sec), .mode_or_program_voltage_pin(vpp),
        .flash_variant(fv), .boot_mode(boot_mode), .pmc_out(pmc_out), .bus_16bit(bus_16bit),
        .rom_access_en(rom_en), .flash_prog_en(fl_en), .reset_entry(reset_entry));
    // 100 MHz clock
    initial begin
        forever #5 pclk = ~pclk;
    end
    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask
    // Reset under a mode, then wait for the port controls to load
    task automatic boot(input logic [1:0] m);
        int n = 0;
        @(posedge pclk);
        presetn <= 1'b0;
        sel <= m;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        do begin
            apb(1'b0, 12'h018, 32'h0);
            n++;
        end while (q[4] !== 1'b1 && n < 20);
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #50000;
        mismatches++;
        report_and_stop;
    end
    // Test sequence
    initial begin
        for (int m = 0; m < 4; m++) begin
            boot(m[1:0]);
            `CHK(boot_mode, m[1:0])
            `CHK(fl_en, m == 2)
            `CHK(reset_entry, 32'h0)
            rd(12'h014, 32'h0000_5555);
            `CHK(bus_16bit, m == 0)
            if (m < 2) begin
                `CHK(rom_en, m == 1)
                `CHK(pmc_out, m == 0 ? 40'hff_ffff_5303 : 40'h0)
                for (int i = 0; i < 4; i++) rd(12'(4 + 4 * i), m == 0 ? pe[i] : 32'h0);
            end
        end
        boot(2'h1);
        for (int i = 0; i < 4; i++) apb(1'b1, 12'(4 + 4 * i), pe[i]);
        rd(12'h004, 32'hff);
        `CHK(pmc_out, 40'hff_ffff_5303)
        apb(1'b1, 12'h000, 32'hffff_ffff);
        rd(12'h000, 32'h03ff_fffe);
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b1, 12'h01c, 32'hffff_fffe);
        rd(12'h020, 32'h0);
        apb(1'b1, 12'h01c, 32'h03ff_effe);
        rd(12'h020, 32'h83ff_f000);
        apb(1'b1, 12'h01c, 32'h03ff_effd);
        rd(12'h020, 32'h03ff_efff);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h024, 32'hf000_0010);
        rd(12'h028, 32'h8000_0010);
        apb(1'b1, 12'h024, 32'hffff_ffff);
        rd(12'h028, 32'h0fff_ffff);
        apb(1'b1, 12'h024, 32'h0002_0000);
        rd(12'h028, 32'hc002_0000);
        apb(1'b1, 12'h024, 32'h0010_0000);
        rd(12'h028, 32'h0010_0000);
        for (int i = 0; i < 14; i++) begin
            apb(1'b1, 12'h02c, vc[i]);
            rd(12'h030, va[i] | (i < 12 ? 32'h8000_0000 : 32'h0));
        end
        rd(12'h034, 32'h0);
        `CHK(e, 1'b1)
        report_and_stop;
    end
endmodule
bind bmam_top bmam_chk u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .mode_select_primary_pin(mode_select_primary_pin),
    .mode_select_secondary_pin(mode_select_secondary_pin),
    .mode_or_program_voltage_pin(mode_or_program_voltage_pin),
    .flash_variant(flash_variant), .boot_mode(boot_mode), .bus_16bit(bus_16bit),
    .rom_access_en(rom_access_en), .flash_prog_en(flash_prog_en), .reset_entry(reset_entry));
`default_nettype wire
